// ===== ddr_ctrl_model.sv
`timescale 1ns/10ps
module ddr_ctrl_model
  import sdram_pkg::*;
#(
  parameter int RST_CYC = 25000
) (
  input wire logic       aclk,
  output logic           mem_reset_n,
  output logic           cke,
  output logic           cs_n,
  output logic           ras_n,
  output logic           cas_n,
  output logic           we_n,
  output logic [2:0]     bank_select_bits,
  output logic [13:0]    addr,
  output logic           termination_control,
  output logic [15:0]    low_byte_lines_i,
  output logic [15:0]    high_byte_lines_i,
  output logic [1:0]     low_byte_strobe_t_i,
  output logic [1:0]     low_byte_strobe_c_i,
  output logic [1:0]     high_byte_strobe_t_i,
  output logic [1:0]     high_byte_strobe_c_i
);
  initial begin
    {mem_reset_n, cke, cs_n, ras_n, cas_n, we_n} = 6'h0f;
    {bank_select_bits, addr, termination_control} = 18'h1;
    {low_byte_lines_i, high_byte_lines_i} = '0;
    {low_byte_strobe_t_i, low_byte_strobe_c_i, high_byte_strobe_t_i, high_byte_strobe_c_i} = '0;
  end

  task automatic power_up(input int wait_cyc);
    repeat (RST_CYC) @(posedge aclk);
    mem_reset_n <= 1'b1;
    repeat (wait_cyc) @(posedge aclk);
    @(posedge aclk); // deselect already registered
    cke <= 1'b1;
    repeat (5) @(posedge aclk);
  endtask : power_up

  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    // Idle edge first, so back-to-back commands never hit the pins twice in one step
    @(posedge aclk);
    {cs_n, ras_n, cas_n, we_n, bank_select_bits, addr} <= {c, b, a};
    @(posedge aclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
  endtask : issue

  task automatic burst(input logic [63:0] l, input logic [63:0] h, input int n, input logic hok);
    for (int c = 0; c < n; c++) begin
      low_byte_lines_i <= l[c*16 +: 16];
      high_byte_lines_i <= h[c*16 +: 16];
      {low_byte_strobe_t_i, low_byte_strobe_c_i} <= 4'h9;
      {high_byte_strobe_t_i, high_byte_strobe_c_i} <= hok ? 4'h9 : 4'ha;
      @(posedge aclk);
    end
    // Released lanes invert and each strobe pair stops disagreeing, so stale data cannot pass as valid
    {low_byte_lines_i, high_byte_lines_i} <= ~{low_byte_lines_i, high_byte_lines_i};
    {low_byte_strobe_c_i, high_byte_strobe_c_i} <= {low_byte_strobe_t_i, high_byte_strobe_t_i};
  endtask : burst
endmodule : ddr_ctrl_model

// ===== sdram_axil_slave.sv
`timescale 1ns/10ps
module sdram_axil_slave
  import sdram_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output      logic                awready,
  input  wire logic [AXI_AW-1:0]   awaddr,
  input  wire logic                wvalid,
  output      logic                wready,
  input  wire logic [AXI_DW-1:0]   wdata,
  input  wire logic [AXI_DW/8-1:0] wstrb,
  output      logic                bvalid,
  input  wire logic                bready,
  output      logic [1:0]          bresp,
  input  wire logic                arvalid,
  output      logic                arready,
  input  wire logic [AXI_AW-1:0]   araddr,
  output      logic                rvalid,
  input  wire logic                rready,
  output      logic [AXI_DW-1:0]   rdata,
  output      logic [1:0]          rresp,
  reg_if.bus                       r
);
  typedef struct packed {
    logic                aw_have;
    logic                w_have;
    logic [AXI_AW-1:0]   awaddr;
    logic [AXI_DW-1:0]   wdata;
    logic [AXI_DW/8-1:0] wstrb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [AXI_DW-1:0]   rdata;
    logic [1:0]          rresp;
  } axil_state_t;

  axil_state_t s_q, s_d;

  always_comb begin
    s_d     = s_q;
    r.wr    = 1'b0;
    r.rd    = 1'b0;
    r.waddr = s_q.awaddr;
    r.wdata = s_q.wdata;
    r.wstrb = s_q.wstrb;
    r.raddr = araddr;
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = wdata;
      s_d.wstrb  = wstrb;
    end
    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
    // Address and data may come in either order; commit once both are held
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      r.wr        = 1'b1;
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = r.werr ? RESP_SLVERR : RESP_OKAY;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
    if (arvalid && s_q.arready) begin
      r.rd       = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rdata  = r.rdata;
      s_d.rresp  = r.rerr ? RESP_SLVERR : RESP_OKAY;
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_q <= '0;
    else          s_q <= s_d;
  end

  assign awready = s_q.awready;
  assign wready  = s_q.wready;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;
endmodule : sdram_axil_slave

// ===== sdram_device.sv
`timescale 1ns/10ps
module sdram_device
  import sdram_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_WAIT_CYCLES,
  parameter int MEM_AW      = 10
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                awvalid,
  output      logic                awready,
  input  wire logic [AXI_AW-1:0]   awaddr,
  input  wire logic                wvalid,
  output      logic                wready,
  input  wire logic [AXI_DW-1:0]   wdata,
  input  wire logic [AXI_DW/8-1:0] wstrb,
  output      logic                bvalid,
  input  wire logic                bready,
  output      logic [1:0]          bresp,
  input  wire logic                arvalid,
  output      logic                arready,
  input  wire logic [AXI_AW-1:0]   araddr,
  output      logic                rvalid,
  input  wire logic                rready,
  output      logic [AXI_DW-1:0]   rdata,
  output      logic [1:0]          rresp,
  input  wire logic                mem_reset_n,
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [BA_W-1:0]     bank_select_bits,
  input  wire logic [ROW_W-1:0]    addr,
  input  wire logic                termination_control,
  input  wire logic [DQ_W-1:0]     low_byte_lines_i,
  output      logic [DQ_W-1:0]     low_byte_lines_o,
  output      logic                low_byte_lines_oe_n,
  input  wire logic [DQ_W-1:0]     high_byte_lines_i,
  output      logic [DQ_W-1:0]     high_byte_lines_o,
  output      logic                high_byte_lines_oe_n,
  input  wire logic [1:0]          low_byte_strobe_t_i,
  input  wire logic [1:0]          low_byte_strobe_c_i,
  output      logic [1:0]          low_byte_strobe_t_o,
  output      logic [1:0]          low_byte_strobe_c_o,
  output      logic                low_byte_strobe_oe_n,
  input  wire logic [1:0]          high_byte_strobe_t_i,
  input  wire logic [1:0]          high_byte_strobe_c_i,
  output      logic [1:0]          high_byte_strobe_t_o,
  output      logic [1:0]          high_byte_strobe_c_o,
  output      logic                high_byte_strobe_oe_n,
  output      logic                data_term_en
);
  localparam int CNT_W = $clog2(INIT_CYCLES + 1);

  initial begin
    if (INIT_CYCLES < 1) $error("sdram_device: INIT_CYCLES must be at least 1");
    if (MEM_AW < 1 || MEM_AW > BA_W + ROW_W + COL_W - BURST_COL_LSB)
      $error("sdram_device: MEM_AW out of range");
  end

  typedef struct packed {
    logic [CNT_W-1:0]               init_cnt;
    logic                           init_done;
    logic                           cke_seen;
    logic                           otf;
    logic                           chop_fixed;
    logic [15:0]                    errs;
    logic [BANKS-1:0]               open;
    logic [BANKS-1:0][ROW_W-1:0]    rows;
    logic                           rd_act;
    logic [1:0]                     rd_clk;
    logic                           rd_chop;
    logic [2:0]                     rd_start;
    logic                           rd_close;
    logic [BA_W-1:0]                rd_bank;
    logic                           wr_act;
    logic [1:0]                     wr_clk;
    logic                           wr_chop;
    logic [2:0]                     wr_start;
    logic                           wr_close;
    logic [BA_W-1:0]                wr_bank;
    logic [MEM_AW-1:0]              wr_addr;
    logic [LINE_W-1:0]              wr_line;
    logic [BE_W-1:0]                wr_be;
    logic [DQ_W-1:0]                low_o;
    logic [DQ_W-1:0]                high_o;
    logic                           dq_oe_n;
    logic [1:0]                     strobe_t;
    logic                           term_en;
  } dev_state_t;

  dev_state_t s_q, s_d;

  reg_if              r ();
  mem_if #(.AW(MEM_AW)) m ();

  sdram_axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .r       (r.bus)
  );

  sdram_line_mem #(.AW(MEM_AW)) u_mem (
    .aclk (aclk),
    .m    (m.mem)
  );

  // Pin order within a burst: sequential, wrapping inside the chopped half
  function automatic logic [2:0] beat_pos(input logic [2:0] start, input logic [2:0] k,
                                          input logic chop);
    logic [1:0] low;
    low = start[1:0] + k[1:0];
    if (chop) beat_pos = {start[2], low};
    else      beat_pos = start + k;
  endfunction : beat_pos

  function automatic logic [MEM_AW-1:0] line_addr(input logic [BA_W-1:0] ba,
                                                  input logic [ROW_W-1:0] row,
                                                  input logic [ROW_W-1:0] col);
    logic [BA_W+ROW_W+COL_W-BURST_COL_LSB-1:0] full;
    full = {ba, row, col[COL_W-1:BURST_COL_LSB]};
    line_addr = full[MEM_AW-1:0];
  endfunction : line_addr

  ////////////////////////////////////////////////////////////////////////////////
  logic [3:0]  cmd;
  logic        cmd_ok;
  logic        chop_now;
  logic [2:0]  pos;
  logic [2:0]  k;
  logic        low_ok;
  logic        high_ok;

  always_comb begin
    s_d     = s_q;
    cmd     = {cs_n, ras_n, cas_n, we_n};
    // Masked commands never reach the decoder
    cmd_ok  = s_q.init_done && s_q.cke_seen && cke && !cs_n;
    chop_now = s_q.otf ? !addr[BURST_HALVING_POS] : s_q.chop_fixed;
    pos     = '0;
    k       = '0;
    // A pair only counts when both halves disagree, single-ended swings are ignored
    low_ok  = &(low_byte_strobe_t_i ^ low_byte_strobe_c_i);
    high_ok = &(high_byte_strobe_t_i ^ high_byte_strobe_c_i);
    m.en    = 1'b0;
    m.we    = 1'b0;
    m.addr  = line_addr(bank_select_bits, s_q.rows[bank_select_bits], addr);
    m.wdata = s_d.wr_line;
    m.be    = '0;

    r.rerr = !(r.raddr == CTRL_OFF || r.raddr == STATUS_OFF || r.raddr == ERRS_OFF);
    r.werr = !(r.waddr == CTRL_OFF || r.waddr == STATUS_OFF || r.waddr == ERRS_OFF);
    r.rdata = '0;
    case (r.raddr)
      CTRL_OFF: begin
        r.rdata[CTRL_OTF_BIT]  = s_q.otf;
        r.rdata[CTRL_CHOP_BIT] = s_q.chop_fixed;
      end
      STATUS_OFF: begin
        r.rdata[ST_INIT_BIT] = s_q.init_done;
        r.rdata[ST_CKE_BIT]  = s_q.cke_seen;
        r.rdata[ST_RD_BIT]   = s_q.rd_act;
        r.rdata[ST_WR_BIT]   = s_q.wr_act;
        r.rdata[ST_OPEN_LSB +: BANKS] = s_q.open;
      end
      ERRS_OFF: r.rdata[15:0] = s_q.errs;
      default:  r.rdata = '0;
    endcase
    if (r.wr && r.waddr == CTRL_OFF && r.wstrb[0]) begin
      s_d.otf        = r.wdata[CTRL_OTF_BIT];
      s_d.chop_fixed = r.wdata[CTRL_CHOP_BIT];
    end
    if (r.wr && r.waddr == ERRS_OFF && r.wstrb[0]) s_d.errs = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Read burst: line arrived from memory, two transfers per clock
    s_d.dq_oe_n  = 1'b1;
    s_d.strobe_t = '0;
    s_d.low_o    = '0;
    s_d.high_o   = '0;
    if (s_q.rd_act) begin
      s_d.dq_oe_n  = 1'b0;
      s_d.strobe_t = STROBE_PHASE;
      for (int h = 0; h < 2; h++) begin
        k   = {s_q.rd_clk, 1'b0} | 3'(h);
        pos = beat_pos(s_q.rd_start, k, s_q.rd_chop);
        s_d.low_o[h*LANE_W +: LANE_W]  = m.rdata[pos*DQ_W +: LANE_W];
        s_d.high_o[h*LANE_W +: LANE_W] = m.rdata[pos*DQ_W + LANE_W +: LANE_W];
      end
      s_d.rd_clk = s_q.rd_clk + 2'h1;
      if (s_q.rd_clk == (s_q.rd_chop ? LAST_CLK_CHOP : LAST_CLK_FULL)) begin
        s_d.rd_act = 1'b0;
        if (s_q.rd_close) s_d.open[s_q.rd_bank] = 1'b0;
      end
    end

    // Write burst: each lane is taken only when its own pair is valid
    if (s_q.wr_act) begin
      for (int h = 0; h < 2; h++) begin
        k   = {s_q.wr_clk, 1'b0} | 3'(h);
        pos = beat_pos(s_q.wr_start, k, s_q.wr_chop);
        if (low_ok) begin
          s_d.wr_line[pos*DQ_W +: LANE_W] = low_byte_lines_i[h*LANE_W +: LANE_W];
          s_d.wr_be[pos*2] = 1'b1;
        end
        if (high_ok) begin
          s_d.wr_line[pos*DQ_W + LANE_W +: LANE_W] = high_byte_lines_i[h*LANE_W +: LANE_W];
          s_d.wr_be[pos*2 + 1] = 1'b1;
        end
      end
      s_d.wr_clk = s_q.wr_clk + 2'h1;
      if (s_q.wr_clk == (s_q.wr_chop ? LAST_CLK_CHOP : LAST_CLK_FULL)) begin
        // Commit the line's enabled bytes (wr_be) in the last beat cycle so the port is free after
        s_d.wr_act = 1'b0;
        m.en    = 1'b1;
        m.we    = 1'b1;
        m.addr  = s_q.wr_addr;
        m.be    = s_d.wr_be;
        // Take the line with the final beat merged in, not the registered copy
        m.wdata = s_d.wr_line;
        if (s_q.wr_close) s_d.open[s_q.wr_bank] = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    if (cmd_ok) begin
      case (cmd)
        CMD_ACTIVE: begin
          if (s_q.open[bank_select_bits]) s_d.errs = s_q.errs + 16'h1;
          else begin
            s_d.open[bank_select_bits] = 1'b1;
            s_d.rows[bank_select_bits] = addr;
          end
        end
        CMD_READ: begin
          // Overlapping bursts and closed banks are refused and counted in errs, no new burst starts
          if (!s_q.open[bank_select_bits] || s_q.rd_act || s_q.wr_act) begin
            s_d.errs = s_q.errs + 16'h1;
          end else begin
            m.en         = 1'b1;
            s_d.rd_act   = 1'b1;
            s_d.rd_clk   = '0;
            s_d.rd_chop  = chop_now;
            s_d.rd_start = addr[2:0];
            s_d.rd_close = addr[AUTO_CLOSE_POS];
            s_d.rd_bank  = bank_select_bits;
          end
        end
        CMD_WRITE: begin
          if (!s_q.open[bank_select_bits] || s_q.rd_act || s_q.wr_act) begin
            s_d.errs = s_q.errs + 16'h1;
          end else begin
            s_d.wr_act   = 1'b1;
            s_d.wr_clk   = '0;
            s_d.wr_chop  = chop_now;
            s_d.wr_start = addr[2:0];
            s_d.wr_close = addr[AUTO_CLOSE_POS];
            s_d.wr_bank  = bank_select_bits;
            s_d.wr_addr  = line_addr(bank_select_bits, s_q.rows[bank_select_bits], addr);
            s_d.wr_be    = '0;
          end
        end
        CMD_PRECHARGE: begin
          if (addr[AUTO_CLOSE_POS]) s_d.open = '0;
          else                      s_d.open[bank_select_bits] = 1'b0;
        end
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal init counts aclk cycles by itself, independent of the controller's wait
    if (!s_q.init_done) begin
      if (s_q.init_cnt == CNT_W'(INIT_CYCLES - 1)) s_d.init_done = 1'b1;
      else s_d.init_cnt = s_q.init_cnt + CNT_W'(1);
    end
    if (cke && s_q.init_done) s_d.cke_seen = 1'b1;
    // Termination only on data lanes, and only once the device is up
    s_d.term_en = termination_control && s_q.cke_seen && !s_d.rd_act && !s_q.rd_act;

    // Device reset pin wipes bursts, banks and init progress
    if (!mem_reset_n) begin
      s_d.init_cnt  = '0;
      s_d.init_done = 1'b0;
      s_d.cke_seen  = 1'b0;
      s_d.open      = '0;
      s_d.rd_act    = 1'b0;
      s_d.wr_act    = 1'b0;
      s_d.dq_oe_n   = 1'b1;
      s_d.term_en   = 1'b0;
      m.en          = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q            <= '0;
      s_q.dq_oe_n    <= 1'b1;
      s_q.otf        <= CTRL_OTF_RST;
      s_q.chop_fixed <= CTRL_CHOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign low_byte_lines_o      = s_q.low_o;
  assign high_byte_lines_o     = s_q.high_o;
  assign low_byte_lines_oe_n   = s_q.dq_oe_n;
  assign high_byte_lines_oe_n  = s_q.dq_oe_n;
  assign low_byte_strobe_t_o   = s_q.strobe_t;
  assign low_byte_strobe_c_o   = ~s_q.strobe_t;
  assign low_byte_strobe_oe_n  = s_q.dq_oe_n;
  assign high_byte_strobe_t_o  = s_q.strobe_t;
  assign high_byte_strobe_c_o  = ~s_q.strobe_t;
  assign high_byte_strobe_oe_n = s_q.dq_oe_n;
  assign data_term_en          = s_q.term_en;
endmodule : sdram_device

// ===== sdram_device_checker.sv
`timescale 1ns/10ps
module sdram_device_checker
  import sdram_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             awvalid,
  input wire logic             awready,
  input wire logic             wvalid,
  input wire logic             wready,
  input wire logic             bvalid,
  input wire logic             arvalid,
  input wire logic             arready,
  input wire logic             rvalid,
  input wire logic             cs_n,
  input wire logic             ras_n,
  input wire logic             cas_n,
  input wire logic             we_n,
  input wire logic [ROW_W-1:0] addr,
  input wire logic             low_byte_lines_oe_n,
  input wire logic             high_byte_lines_oe_n,
  input wire logic [1:0]       low_byte_strobe_t_o,
  input wire logic [1:0]       low_byte_strobe_c_o,
  input wire logic             data_term_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic oe_n = low_byte_lines_oe_n;
  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  //////////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($rose(aresetn) |-> oe_n && !bvalid && !data_term_en)
    else $error("outputs not idle after reset");
  read_cause_a: assert property ($fell(oe_n) |-> $past(cmd, 2) == CMD_READ)
    else $error("data driven without selected read");
  lane_pair_a: assert property (oe_n == high_byte_lines_oe_n)
    else $error("byte lanes out of step");
  strobe_diff_a: assert property (!oe_n |-> low_byte_strobe_c_o == ~low_byte_strobe_t_o)
    else $error("strobe pair not complementary");
  strobe_edge_a: assert property (!oe_n |-> low_byte_strobe_t_o == STROBE_PHASE)
    else $error("read strobe not edge aligned");
  full_burst_a: assert property ($fell(oe_n) && $past(addr[12], 2) |-> !oe_n[*4] ##1 oe_n)
    else $error("full burst length wrong");
  chop_burst_a: assert property ($fell(oe_n) && !$past(addr[12], 2) |-> !oe_n[*2] ##1 oe_n)
    else $error("chopped burst length wrong");
  term_off_a: assert property (!oe_n |-> !data_term_en)
    else $error("termination on while driving");
  write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  cover property ($fell(oe_n) && $past(addr[12], 2));
  cover property ($fell(oe_n) && !$past(addr[12], 2));
  cover property (arvalid && arready);
endmodule : sdram_device_checker

bind sdram_device sdram_device_checker i_chk (.*);

// ===== sdram_device_test.sv
`timescale 1ns/10ps
module sdram_device_test;
  import sdram_pkg::*;
  localparam int INIT = 16;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, mem_reset_n, cke, cs_n, ras_n, cas_n, we_n, termination_control;
  logic low_byte_lines_oe_n, high_byte_lines_oe_n, low_byte_strobe_oe_n;
  logic high_byte_strobe_oe_n, data_term_en;
  logic [1:0] bresp, rresp, low_byte_strobe_t_i, low_byte_strobe_c_i, low_byte_strobe_t_o;
  logic [1:0] low_byte_strobe_c_o, high_byte_strobe_t_i, high_byte_strobe_c_i;
  logic [1:0] high_byte_strobe_t_o, high_byte_strobe_c_o;
  logic [7:0] awaddr, araddr, lo_col[8], hi_col[8];
  logic [31:0] wdata, rdata, exp_dq[$];
  logic [33:0] exp_rd[$];
  logic [1:0] exp_b[$];
  logic [3:0] wstrb;
  logic [2:0] bank_select_bits;
  logic [13:0] addr;
  logic [15:0] low_byte_lines_i, low_byte_lines_o, high_byte_lines_i, high_byte_lines_o;
  int num_errors, num_checks;
  int seed = 84;

  sdram_device #(.INIT_CYCLES(INIT)) i_dut (.*);
  ddr_ctrl_model #(.RST_CYC(4)) i_ctrl (.*);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    int n;
    exp_b.push_back(er);
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'h7};
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 99) begin
      num_errors++;
      report_and_stop();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad, input logic [33:0] e);
    int n;
    exp_rd.push_back(e);
    {araddr, arvalid, rready} <= {ad, 2'h3};
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 99) begin
      num_errors++;
      report_and_stop();
    end
  endtask : axi_rd

  function automatic int col(input int s, input int k, input logic ch);
    return ch ? (s & 4) | ((s + k) & 3) : (s + k) & 7;
  endfunction : col

  task automatic wr_burst(input int s, input logic ch, input logic hok);
    logic [63:0] l, h;
    for (int k = 0; k < 8; k++) begin
      l[k*8 +: 8] = 8'($random(seed));
      h[k*8 +: 8] = 8'($random(seed));
      if (k < (ch ? 4 : 8)) lo_col[col(s, k, ch)] = l[k*8 +: 8];
      if (k < (ch ? 4 : 8) && hok) hi_col[col(s, k, ch)] = h[k*8 +: 8];
    end
    i_ctrl.issue(CMD_WRITE, 3'h1, {1'b0, !ch, 2'h0, 10'(s)});
    i_ctrl.burst(l, h, ch ? 2 : 4, hok);
  endtask : wr_burst

  task automatic rd_burst(input int s, input logic ch, input logic ac);
    for (int c = 0; c < (ch ? 2 : 4); c++) begin
      exp_dq.push_back({hi_col[col(s, 2*c+1, ch)], hi_col[col(s, 2*c, ch)],
                        lo_col[col(s, 2*c+1, ch)], lo_col[col(s, 2*c, ch)]});
    end
    i_ctrl.issue(CMD_READ, 3'h1, {1'b0, !ch, 1'b0, ac, 10'(s)});
    repeat (6) @(posedge aclk);
  endtask : rd_burst

  always @(posedge aclk) begin
    if (!low_byte_lines_oe_n) chk("dq", 34'(exp_dq.pop_front()), {2'h0, high_byte_lines_o, low_byte_lines_o});
    if (rvalid && rready) chk("rdata", exp_rd.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", 34'(exp_b.pop_front()), 34'(bresp));
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(CTRL_OFF, {RESP_OKAY, 32'h1});
    axi_rd(STATUS_OFF, {RESP_OKAY, 32'h0});
    axi_wr(8'h0c, 32'h1, RESP_SLVERR);
    axi_rd(8'h0c, {RESP_SLVERR, 32'h0});
    i_ctrl.power_up(INIT + 2);
    axi_rd(STATUS_OFF, {RESP_OKAY, 32'h3});
    i_ctrl.issue(CMD_ACTIVE, 3'h1, 14'h0123);
    wr_burst(0, 1'b0, 1'b1);
    wr_burst(4, 1'b1, 1'b0);
    rd_burst(4, 1'b0, 1'b0);
    axi_rd(STATUS_OFF, {RESP_OKAY, 32'h203});
    rd_burst(2, 1'b1, 1'b1);
    i_ctrl.issue(4'hd, 3'h1, 14'h1000);
    i_ctrl.issue(CMD_READ, 3'h1, 14'h1000);
    axi_rd(ERRS_OFF, {RESP_OKAY, 32'h1});
    axi_wr(ERRS_OFF, 32'h0, RESP_OKAY);
    axi_rd(ERRS_OFF, {RESP_OKAY, 32'h0});
    i_ctrl.issue(CMD_ACTIVE, 3'h2, 14'h0);
    i_ctrl.issue(CMD_PRECHARGE, 3'h0, 14'h0400);
    axi_rd(STATUS_OFF, {RESP_OKAY, 32'h3});
    chk("dq left", 34'h0, 34'(exp_dq.size()));
    report_and_stop();
  end
endmodule : sdram_device_test

// ===== sdram_ifs.sv
`timescale 1ns/10ps
interface reg_if;
  import sdram_pkg::*;
  logic                wr;
  logic                rd;
  logic [AXI_AW-1:0]   waddr;
  logic [AXI_AW-1:0]   raddr;
  logic [AXI_DW-1:0]   wdata;
  logic [AXI_DW/8-1:0] wstrb;
  logic [AXI_DW-1:0]   rdata;
  logic                werr;
  logic                rerr;
  modport bus  (output wr, rd, waddr, raddr, wdata, wstrb, input rdata, werr, rerr);
  modport regs (input wr, rd, waddr, raddr, wdata, wstrb, output rdata, werr, rerr);
endinterface : reg_if

interface mem_if #(parameter int AW = 10);
  import sdram_pkg::*;
  logic              en;
  logic              we;
  logic [AW-1:0]     addr;
  logic [LINE_W-1:0] wdata;
  logic [BE_W-1:0]   be;
  logic [LINE_W-1:0] rdata;
  modport user (output en, we, addr, wdata, be, input rdata);
  modport mem  (input en, we, addr, wdata, be, output rdata);
endinterface : mem_if

// ===== sdram_line_mem.sv
`timescale 1ns/10ps
module sdram_line_mem
  import sdram_pkg::*;
#(
  parameter int AW = 10
) (
  input wire logic aclk,
  mem_if.mem       m
);
  // Whole prefetch line per word: one access feeds four pin clocks
  logic [LINE_W-1:0] array [2**AW];

  initial begin
    if (AW < 1 || AW > 20) $error("sdram_line_mem: AW out of range");
  end

  always_ff @(posedge aclk) begin
    if (m.en) begin
      for (int b = 0; b < BE_W; b++) begin
        if (m.we && m.be[b]) array[m.addr][b*LANE_W +: LANE_W] <= m.wdata[b*LANE_W +: LANE_W];
      end
      m.rdata <= array[m.addr];
    end
  end
endmodule : sdram_line_mem

// ===== sdram_pkg.sv
package sdram_pkg;

  localparam int BANKS   = 8;
  localparam int BA_W    = 3;
  localparam int ROW_W   = 14;
  localparam int COL_W   = 10;
  localparam int LANE_W  = 8;
  localparam int DQ_W    = 2 * LANE_W;
  localparam int BEATS   = 8;
  localparam int LINE_W  = DQ_W * BEATS;
  localparam int BE_W    = LINE_W / LANE_W;

  // Command code is {chip select, row strobe, column strobe, write enable}, all active low
  localparam logic [3:0] CMD_ACTIVE    = 4'h3;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;

  localparam int AUTO_CLOSE_POS    = 10;
  localparam int BURST_HALVING_POS = 12;
  localparam int BURST_COL_LSB     = 3;

  localparam logic [1:0] LAST_CLK_FULL = 2'h3;
  localparam logic [1:0] LAST_CLK_CHOP = 2'h1;
  localparam logic [1:0] STROBE_PHASE  = 2'h1;

  localparam int CLK_PS            = 8000;
  localparam int INIT_WAIT_US      = 500;
  localparam int INIT_WAIT_CYCLES  = (INIT_WAIT_US * 1000 * 1000 + CLK_PS - 1) / CLK_PS;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [AXI_AW-1:0] CTRL_OFF   = 8'h00;
  localparam logic [AXI_AW-1:0] STATUS_OFF = 8'h04;
  localparam logic [AXI_AW-1:0] ERRS_OFF   = 8'h08;
  localparam int CTRL_OTF_BIT   = 0;
  localparam int CTRL_CHOP_BIT  = 1;
  localparam int ST_INIT_BIT    = 0;
  localparam int ST_CKE_BIT     = 1;
  localparam int ST_RD_BIT      = 2;
  localparam int ST_WR_BIT      = 3;
  localparam int ST_OPEN_LSB    = 8;
  localparam logic CTRL_OTF_RST  = 1'h1;
  localparam logic CTRL_CHOP_RST = 1'h0;

endpackage : sdram_pkg
